// ### rtl/rtc_calendar_regs.vh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: word-addressed plain register port, byte offsets as printed
// Notes:   definitions only
`ifndef RTC_CALENDAR_REGS_VH
`define RTC_CALENDAR_REGS_VH

// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define OFS_CTRL       32'h0ffffeb0
`define OFS_MODE       32'h0ffffeb4
`define OFS_TIME       32'h0ffffeb8
`define OFS_CAL        32'hfffffebc
`define OFS_TALARM     32'hfffffec0
`define OFS_CALARM     32'hfffffec4
`define OFS_STATUS     32'h0ffffec8
`define OFS_CLEAR      32'hfffffecc
`define OFS_IRQ_EN     32'hfffffed0
`define OFS_IRQ_DIS    32'hfffffed4
`define OFS_IRQ_MASK   32'hfffffed8
`define OFS_VALID      32'hfffffedc

// ----------------------------------------------------------------
// status bit positions
// ----------------------------------------------------------------
`define ST_ACK         0
`define ST_ALARM       1
`define ST_SEC         2
`define ST_CLOCK_EVENT_FLAG       3
`define ST_CALENDAR_EVENT_FLAG       4

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define POS_MERIDIEM   22
`define POS_SS_EN      7
`define POS_MM_EN      15
`define POS_HH_EN      23
`define POS_DD_EN      31
`define POS_MO_EN      23

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_CAL        32'h01210720
`define RST_CALARM     32'h01010000
`define CENTURY_BCD    8'h20

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ         10000000
`define SECOND_NS      1000000000
`define SECOND_CYCLES  (`SECOND_NS / (1000000000 / `CLK_HZ))

`endif

// ### rtl/rtc_time_calendar_alarm.v
// Purpose: real-time clock counters, alarms and sticky event flags
// Assumes: clk_sys at 10 MHz; second tick from a divider of clk_sys
// Notes:   registers over a plain strobe port, read data one cycle later
//
// Behaviour
// - mode bit 0 selects 24-hour form, 1 selects 12-hour form.
// - seconds and minutes accept BCD 00 to 59 only.
// - units digit in low nibble, tens digit directly above.
// - hour accepts 1-12 in 12-hour form, 0-23 in 24-hour form.
// - meridiem bit above hour field, 0 morning, 1 afternoon.
// - century field accepts only BCD 20.
// - year accepts any BCD value 00 to 99.
// - month accepts BCD 01 to 12 only.
// - weekday accepts 1 to 7 and does not affect date.
// - date accepts BCD 01 to 31 only.
// - time alarm compares enabled second, minute, hour/meridiem fields.
// - date alarm compares enabled date and month fields.
// - update-granted flag reads 1 only while counters may be written.
// - alarm flag sets when all enabled fields match, sticky.
// - second flag sets each tick and stays until cleared.
// - time-event flag latches selected minute/hour/noon/midnight event.
// - calendar-event flag latches selected week/month/year event.
// - writing 1 to a clear bit clears that flag; 0 does nothing.
// - illegal entries not loaded; validity flag clears on a good write.
// - update request stops counters and grants within one second.
// - each flag reaches irq only while its mask bit is set.
//
// Strobed register access was decided locally.
`timescale 1ns/100ps
`include "rtc_calendar_regs.vh"

module rtc_time_calendar_alarm #(
  parameter SECOND_CYCLES = `SECOND_CYCLES
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // register port
  input  wire [31:0] regAddr,
  input  wire [31:0] regWrData,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [31:0] regRdData,
  // interrupt line
  output wire        irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function bcdOk;
    input [7:0] v;
    input [7:0] lo;
    input [7:0] hi;
    begin
      bcdOk = (v[3:0] < 4'ha) && (v[7:4] < 4'ha) && (v >= lo) && (v <= hi);
    end
  endfunction

  function [7:0] bcdInc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9) begin
        bcdInc = {v[7:4] + 4'h1, 4'h0};
      end else begin
        bcdInc = {v[7:4], v[3:0] + 4'h1};
      end
    end
  endfunction

  // last date of a month, year counted inside century 20
  function [7:0] monthEnd;
    input [7:0] mo;
    input [7:0] yr;
    reg         leap;
    begin
      leap = (yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                    : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8));
      if (mo == 8'h02) begin
        monthEnd = leap ? 8'h29 : 8'h28;
      end else if (mo == 8'h04 || mo == 8'h06 || mo == 8'h09 || mo == 8'h11) begin
        monthEnd = 8'h30;
      end else begin
        monthEnd = 8'h31;
      end
    end
  endfunction

  // hour plus meridiem legal for the chosen form
  function hourOk;
    input [6:0] hh;
    input       pm;
    input       twelve;
    begin
      if (twelve) begin
        hourOk = bcdOk({2'b00, hh[5:0]}, 8'h01, 8'h12);
      end else begin
        hourOk = bcdOk({2'b00, hh[5:0]}, 8'h00, 8'h23) && !pm;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg        hourFormatSelect;
  reg  [6:0] secs, mins;
  reg  [5:0] hours;
  reg        meridiemFlag;
  reg  [7:0] century, year;
  reg  [4:0] month;
  reg  [2:0] weekday;
  reg  [5:0] date;
  reg [31:0] timeAlarm, dateAlarm;
  reg        haltClockForWrite, haltCalendarForWrite;
  reg  [1:0] clockEventChoice, calendarEventChoice;
  reg  [4:0] status, irqMask;
  reg  [3:0] validity;
  reg [31:0] divCnt;
  reg        alarmSeen;

  wire       tick = (divCnt == SECOND_CYCLES - 1);
  wire       wrCtrl = regWr && (regAddr == `OFS_CTRL);
  wire       halted = haltClockForWrite || haltCalendarForWrite;

  // write strobes, one per register
  wire       wrMode   = regWr && (regAddr == `OFS_MODE);
  wire       wrTime   = regWr && (regAddr == `OFS_TIME);
  wire       wrCal    = regWr && (regAddr == `OFS_CAL);
  wire       wrTalarm = regWr && (regAddr == `OFS_TALARM);
  wire       wrCalarm = regWr && (regAddr == `OFS_CALARM);
  wire       wrClear  = regWr && (regAddr == `OFS_CLEAR);
  wire       wrIrqEn  = regWr && (regAddr == `OFS_IRQ_EN);
  wire       wrIrqDis = regWr && (regAddr == `OFS_IRQ_DIS);

  // incoming time-of-day and calendar fields
  wire [6:0] wSec  = regWrData[6:0];
  wire [6:0] wMin  = regWrData[14:8];
  wire [5:0] wHour = regWrData[21:16];
  wire       wPm   = regWrData[`POS_MERIDIEM];
  wire [7:0] wCent = regWrData[7:0];
  wire [7:0] wYear = regWrData[15:8];
  wire [4:0] wMon  = regWrData[20:16];
  wire [2:0] wDay  = regWrData[23:21];
  wire [5:0] wDate = regWrData[29:24];

  wire timeOk = bcdOk({1'b0, wSec}, 8'h00, 8'h59) &&
                bcdOk({1'b0, wMin}, 8'h00, 8'h59) &&
                hourOk({1'b0, wHour}, wPm, hourFormatSelect);
  wire calOk  = (wCent == `CENTURY_BCD) &&
                bcdOk(wYear, 8'h00, 8'h99) &&
                bcdOk({3'b000, wMon}, 8'h01, 8'h12) &&
                (wDay >= 3'h1) && (wDay <= 3'h7) &&
                bcdOk({2'b00, wDate}, 8'h01, 8'h31) &&
                ({2'b00, wDate} <= monthEnd({3'b000, wMon}, wYear));
  wire talOk  = bcdOk({1'b0, regWrData[6:0]}, 8'h00, 8'h59) &&
                bcdOk({1'b0, regWrData[14:8]}, 8'h00, 8'h59) &&
                hourOk(regWrData[22:16], regWrData[`POS_MERIDIEM], hourFormatSelect);
  wire calAlOk = bcdOk({3'b000, regWrData[20:16]}, 8'h01, 8'h12) &&
                 bcdOk({2'b00, regWrData[29:24]}, 8'h01, 8'h31);

  // ----------------------------------------------------------------
  // alarm compare
  // ----------------------------------------------------------------
  wire anyEn = timeAlarm[`POS_SS_EN] | timeAlarm[`POS_MM_EN] | timeAlarm[`POS_HH_EN] |
               dateAlarm[`POS_DD_EN] | dateAlarm[`POS_MO_EN];
  wire alarmMatch = anyEn &&
    (!timeAlarm[`POS_SS_EN] || timeAlarm[6:0] == secs) &&
    (!timeAlarm[`POS_MM_EN] || timeAlarm[14:8] == mins) &&
    (!timeAlarm[`POS_HH_EN] || timeAlarm[22:16] == {meridiemFlag, hours}) &&
    (!dateAlarm[`POS_DD_EN] || dateAlarm[29:24] == date) &&
    (!dateAlarm[`POS_MO_EN] || dateAlarm[20:16] == month);

  // ----------------------------------------------------------------
  // roll-over decode
  // ----------------------------------------------------------------
  wire runTime = tick && !haltClockForWrite;
  wire minWrap = runTime && (secs == 7'h59);
  wire hourWrap = minWrap && (mins == 7'h59);
  wire lastHour = hourFormatSelect ? (hours == 6'h11 && meridiemFlag) : (hours == 6'h23);
  wire dayWrap = hourWrap && lastHour;
  wire noonHit = hourWrap && (hourFormatSelect ? (hours == 6'h11 && !meridiemFlag)
                                               : (hours == 6'h11));
  // a time halt also freezes the calendar: the day carry never arrives
  wire calRun  = dayWrap && !haltCalendarForWrite;
  wire monWrap = calRun && ({2'b00, date} == monthEnd({3'b000, month}, year));
  wire yrWrap  = monWrap && (month == 5'h12);
  wire weekHit = calRun && (weekday == 3'h7);
  reg  timeEvt, calEvt;
  always @* begin
    case (clockEventChoice)
      2'h0:    timeEvt = minWrap;
      2'h1:    timeEvt = hourWrap;
      2'h2:    timeEvt = dayWrap;
      default: timeEvt = noonHit;
    endcase
    case (calendarEventChoice)
      2'h0:    calEvt = weekHit;
      2'h1:    calEvt = monWrap;
      default: calEvt = yrWrap;
    endcase
  end

  // ----------------------------------------------------------------
  // next counter values
  // ----------------------------------------------------------------
  // the bcd helper works on bytes; counters are narrower, so cut on purpose
  wire [7:0] incSec   = bcdInc({1'b0, secs});
  wire [7:0] incMin   = bcdInc({1'b0, mins});
  wire [7:0] incHour  = bcdInc({2'b00, hours});
  wire [7:0] incMonth = bcdInc({3'b000, month});
  wire [7:0] incDate  = bcdInc({2'b00, date});

  // ----------------------------------------------------------------
  // counters and registers
  // ----------------------------------------------------------------
  wire [4:0] clr = wrClear ? regWrData[4:0] : 5'h00;
  wire [4:0] setEv = {calEvt, timeEvt, tick, alarmMatch && !alarmSeen,
                      halted && tick};

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hourFormatSelect     <= 1'b0;
      secs                 <= 7'h00;
      mins                 <= 7'h00;
      hours                <= 6'h00;
      meridiemFlag         <= 1'b0;
      century              <= `CENTURY_BCD;
      year                 <= 8'h07;
      month                <= 5'h01;
      weekday              <= 3'h1;
      date                 <= 6'h01;
      timeAlarm            <= 32'h00000000;
      dateAlarm            <= `RST_CALARM;
      haltClockForWrite    <= 1'b0;
      haltCalendarForWrite <= 1'b0;
      clockEventChoice     <= 2'h0;
      calendarEventChoice  <= 2'h0;
      status               <= 5'h00;
      irqMask              <= 5'h00;
      validity             <= 4'h0;
      divCnt               <= 32'h00000000;
      alarmSeen            <= 1'b0;
    end else begin
      // divider restarts on every tick, one tick per second of clk_sys
      divCnt    <= tick ? 32'h00000000 : divCnt + 32'h00000001;
      // alarm flag takes the rising match only, so a held match sets it once
      alarmSeen <= alarmMatch;
      // sticky flags: a set in the clearing cycle wins
      status <= (status & ~clr) | setEv;
      // granted drops as soon as both halts are released
      if (!halted) begin
        status[`ST_ACK] <= 1'b0;
      end
      if (wrCtrl) begin
        haltClockForWrite    <= regWrData[0];
        haltCalendarForWrite <= regWrData[1];
        clockEventChoice     <= regWrData[9:8];
        calendarEventChoice  <= regWrData[17:16];
      end
      if (wrMode) begin
        hourFormatSelect <= regWrData[0];
      end
      if (wrIrqEn) begin
        irqMask <= irqMask | regWrData[4:0];
      end
      if (wrIrqDis) begin
        irqMask <= irqMask & ~regWrData[4:0];
      end
      // time counting
      if (runTime) begin
        secs <= (secs == 7'h59) ? 7'h00 : incSec[6:0];
        if (minWrap) begin
          mins <= (mins == 7'h59) ? 7'h00 : incMin[6:0];
        end
        if (hourWrap) begin
          if (hourFormatSelect) begin
            if (hours == 6'h12) begin
              hours <= 6'h01;
            end else begin
              hours <= incHour[5:0];
              if (hours == 6'h11) begin
                meridiemFlag <= ~meridiemFlag;
              end
            end
          end else begin
            hours <= (hours == 6'h23) ? 6'h00 : incHour[5:0];
          end
        end
      end
      if (calRun) begin
        weekday <= (weekday == 3'h7) ? 3'h1 : weekday + 3'h1;
        date <= monWrap ? 6'h01 : incDate[5:0];
        if (monWrap) begin
          month <= (month == 5'h12) ? 5'h01 : incMonth[4:0];
        end
        if (yrWrap) begin
          year <= (year == 8'h99) ? 8'h00 : bcdInc(year);
        end
      end
      // software loads, checked before they land
      if (wrTime && haltClockForWrite) begin
        validity[0] <= !timeOk;
        if (timeOk) begin
          secs         <= wSec;
          mins         <= wMin;
          hours        <= wHour;
          meridiemFlag <= hourFormatSelect & wPm;
        end
      end
      if (wrCal && haltCalendarForWrite) begin
        validity[1] <= !calOk;
        if (calOk) begin
          century <= wCent;
          year    <= wYear;
          month   <= wMon;
          weekday <= wDay;
          date    <= wDate;
        end
      end
      // alarms may change any time; software gates with the enables
      if (wrTalarm) begin
        validity[2] <= !talOk;
        if (talOk) begin
          // enables sit in the top bit of each of the three low bytes and must be kept
          timeAlarm <= regWrData & 32'h00ffffff;
        end
      end
      if (wrCalarm) begin
        validity[3] <= !calAlOk;
        if (calAlOk) begin
          dateAlarm <= regWrData & 32'hbf9f0000;
        end
      end
    end
  end

  assign irq = |(status & irqMask);

  // ----------------------------------------------------------------
  // read port; unmapped offsets read zero
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      regRdData <= 32'h00000000;
    end else if (!regRd) begin
      regRdData <= 32'h00000000;
    end else if (regAddr == `OFS_CTRL) begin
      regRdData <= {14'h0000, calendarEventChoice, 6'h00, clockEventChoice, 6'h00,
                    haltCalendarForWrite, haltClockForWrite};
    end else if (regAddr == `OFS_MODE) begin
      regRdData <= {31'h00000000, hourFormatSelect};
    end else if (regAddr == `OFS_TIME) begin
      regRdData <= {9'h000, meridiemFlag, hours, 1'b0, mins, 1'b0, secs};
    end else if (regAddr == `OFS_CAL) begin
      regRdData <= {2'b00, date, weekday, month, year, century};
    end else if (regAddr == `OFS_TALARM) begin
      regRdData <= timeAlarm;
    end else if (regAddr == `OFS_CALARM) begin
      regRdData <= dateAlarm;
    end else if (regAddr == `OFS_STATUS) begin
      regRdData <= {27'h0000000, status};
    end else if (regAddr == `OFS_IRQ_MASK) begin
      regRdData <= {27'h0000000, irqMask};
    end else if (regAddr == `OFS_VALID) begin
      regRdData <= {28'h0000000, validity};
    end else begin
      regRdData <= 32'h00000000;
    end
  end

endmodule

// ### tb/rtc_time_calendar_alarm_chk.sv
// Purpose: port-level checks of the clock/calendar block
// Assumes: read data stands only in the cycle after the read strobe
// Notes:   field checks apply to whatever software reads back
`timescale 1ns/100ps
`include "rtc_calendar_regs.vh"
module rtc_time_calendar_alarm_chk (
  // clock and reset
  input wire        clk_sys,
  input wire        rst,
  // register port
  input wire [31:0] regAddr,
  input wire [31:0] regWrData,
  input wire        regWr,
  input wire        regRd,
  input wire [31:0] regRdData,
  // interrupt line
  input wire        irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  // bcd digits compare in hex order, so one bound covers the tens digit; the units digit gets its own
  function automatic logic bcdLe(input logic [7:0] v, input logic [7:0] mx);
    return (v[3:0] <= 4'h9) && (v <= mx);
  endfunction
  wire rdTime = regRd && (regAddr == `OFS_TIME);
  wire rdCal  = regRd && (regAddr == `OFS_CAL);
  property p_rd_idle;
    !$past(regRd) |-> regRdData == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_status_bits;
    regRd && regAddr == `OFS_STATUS |=> regRdData[31:5] == 27'h0;
  endproperty
  a_status_bits: assert property (p_status_bits) else $error("status spare bits set");
  property p_mode_bits;
    regRd && regAddr == `OFS_MODE |=> regRdData[31:1] == 31'h0;
  endproperty
  a_mode_bits: assert property (p_mode_bits) else $error("mode spare bits set");
  property p_time_ss;
    rdTime |=> bcdLe(regRdData[7:0], 8'h59);
  endproperty
  a_time_ss: assert property (p_time_ss) else $error("seconds out of range");
  property p_time_mm;
    rdTime |=> bcdLe(regRdData[15:8], 8'h59);
  endproperty
  a_time_mm: assert property (p_time_mm) else $error("minutes out of range");
  property p_time_hh;
    rdTime |=> bcdLe({2'b00, regRdData[21:16]}, 8'h23) && regRdData[31:23] == 9'h0;
  endproperty
  a_time_hh: assert property (p_time_hh) else $error("hour out of range");
  property p_cal_hundreds_of_years_field;
    rdCal |=> regRdData[7:0] == `CENTURY_BCD;
  endproperty
  a_cal_hundreds_of_years_field: assert property (p_cal_hundreds_of_years_field) else $error("century not 20");
  property p_cal_year;
    rdCal |=> bcdLe(regRdData[15:8], 8'h99);
  endproperty
  a_cal_year: assert property (p_cal_year) else $error("year not bcd");
  property p_cal_month;
    rdCal |=> bcdLe({3'b000, regRdData[20:16]}, 8'h12) && regRdData[20:16] != 5'h0;
  endproperty
  a_cal_month: assert property (p_cal_month) else $error("month out of range");
  property p_cal_day;
    rdCal |=> regRdData[23:21] != 3'h0;
  endproperty
  a_cal_day: assert property (p_cal_day) else $error("weekday out of range");
  property p_cal_date;
    rdCal |=> bcdLe({2'b00, regRdData[29:24]}, 8'h31) && regRdData[31:24] != 8'h0;
  endproperty
  a_cal_date: assert property (p_cal_date) else $error("date out of range");
endmodule
bind rtc_time_calendar_alarm rtc_time_calendar_alarm_chk u_chk (
  .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
  .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irq(irq));

// ### tb/rtc_time_calendar_alarm_tb.sv
// Purpose: directed scenarios for the clock/calendar block
// Assumes: one second shortened to ten clocks
// Notes:   one day or hour rollover is reached by presetting the counters
`timescale 1ns/100ps
`include "rtc_calendar_regs.vh"
module rtc_time_calendar_alarm_tb;
  reg         clk_sys;
  reg         rst;
  reg  [31:0] regAddr;
  reg  [31:0] regWrData;
  reg         regWr;
  reg         regRd;
  wire [31:0] regRdData;
  wire        irq;
  integer     errors;
  integer     testsRun;
  integer     cycles;
  reg  [31:0] d;

  rtc_time_calendar_alarm #(.SECOND_CYCLES(10)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irq(irq));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      end_of_test;
    end
  end
  task end_of_test;
    begin
      $display("comparisons %0d mismatches %0d", testsRun, errors);
      if (errors == 0 && testsRun > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      testsRun = testsRun + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [31:0] a, input [31:0] v);
    begin
      @(posedge clk_sys);
      regWr     <= 1'b1;
      regAddr   <= a;
      regWrData <= v;
      @(posedge clk_sys);
      regWr     <= 1'b0;
    end
  endtask
  task rd(input [31:0] a, output [31:0] v);
    begin
      @(posedge clk_sys);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge clk_sys);
      regRd   <= 1'b0;
      @(negedge clk_sys);
      v = regRdData;
    end
  endtask
  // polling is bounded: a tick is due every ten clocks
  task wait_time(input [31:0] old);
    integer n;
    begin
      n = 0;
      d = old;
      while (d === old && n < 40) begin
        rd(`OFS_TIME, d);
        n = n + 1;
      end
    end
  endtask
  task poll(input integer b);
    integer n;
    begin
      n = 0;
      d = 32'h0;
      while (d[b] !== 1'b1 && n < 80) begin
        rd(`OFS_STATUS, d);
        n = n + 1;
      end
      chk({31'h0, d[b]}, 32'h1);
    end
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_reset;
    begin
      rd(`OFS_TIME, d);   chk(d, 32'h0);
      rd(`OFS_CAL, d);    chk(d, `RST_CAL);
      rd(`OFS_TALARM, d); chk(d, 32'h0);
      rd(`OFS_CALARM, d); chk(d, `RST_CALARM);
      rd(`OFS_MODE, d);   chk(d, 32'h0);
      rd(32'h0, d);       chk(d, 32'h0);
      $display("reset values done");
    end
  endtask
  task t_update;
    begin
      wr(`OFS_CTRL, 32'h3);
      poll(`ST_ACK);
      wr(`OFS_TIME, 32'h00235958);
      rd(`OFS_TIME, d); chk(d, 32'h00235958);
      wr(`OFS_TIME, 32'h00235960);
      rd(`OFS_TIME, d); chk(d, 32'h00235958);
      rd(`OFS_VALID, d); chk(d & 32'h1, 32'h1);
      wr(`OFS_TIME, 32'h00235959);
      rd(`OFS_VALID, d); chk(d & 32'h1, 32'h0);
      wr(`OFS_CAL, 32'h31f29921);
      rd(`OFS_CAL, d); chk(d, `RST_CAL);
      rd(`OFS_VALID, d); chk(d & 32'h2, 32'h2);
      wr(`OFS_CAL, 32'h31f39920);
      rd(`OFS_CAL, d); chk(d, `RST_CAL);
      wr(`OFS_CAL, 32'h31f29920);
      rd(`OFS_CAL, d); chk(d, 32'h31f29920);
      wr(`OFS_CLEAR, 32'h1f);
      wr(`OFS_CTRL, 32'h00020200);
      rd(`OFS_STATUS, d); chk(d & 32'h1, 32'h0);
      $display("update done");
    end
  endtask
  task t_rollover;
    begin
      wait_time(32'h00235959); chk(d, 32'h0);
      rd(`OFS_CAL, d); chk(d, 32'h01210020);
      rd(`OFS_STATUS, d); chk(d & 32'h1c, 32'h1c);
      wr(`OFS_CLEAR, 32'h0);
      rd(`OFS_STATUS, d); chk(d & 32'h18, 32'h18);
      wr(`OFS_CLEAR, 32'h10);
      rd(`OFS_STATUS, d); chk(d & 32'h18, 32'h08);
      $display("rollover done");
    end
  endtask
  task t_twelve;
    begin
      wr(`OFS_CTRL, 32'h1);
      poll(`ST_ACK);
      wr(`OFS_MODE, 32'h1);
      rd(`OFS_MODE, d); chk(d, 32'h1);
      wr(`OFS_TIME, 32'h00135959);
      rd(`OFS_VALID, d); chk(d & 32'h1, 32'h1);
      wr(`OFS_TIME, 32'h00115959);
      rd(`OFS_TIME, d); chk(d, 32'h00115959);
      wr(`OFS_CTRL, 32'h0);
      wait_time(32'h00115959); chk(d, 32'h00520000);
      $display("twelve hour done");
    end
  endtask
  task t_alarm;
    begin
      wr(`OFS_CLEAR, 32'h2);
      // hour field kept legal: 00 is refused in 12-hour form
      wr(`OFS_TALARM, 32'h00120085);
      rd(`OFS_TALARM, d); chk(d, 32'h00120085);
      rd(`OFS_STATUS, d); chk(d & 32'h2, 32'h0);
      poll(`ST_ALARM);
      rd(`OFS_TIME, d); chk(d & 32'hff, 32'h05);
      @(negedge clk_sys); chk({31'h0, irq}, 32'h0);
      wr(`OFS_IRQ_EN, 32'h2);
      @(negedge clk_sys); chk({31'h0, irq}, 32'h1);
      rd(`OFS_IRQ_MASK, d); chk(d, 32'h2);
      wr(`OFS_IRQ_DIS, 32'h2);
      @(negedge clk_sys); chk({31'h0, irq}, 32'h0);
      wr(`OFS_TALARM, 32'h00120005);
      wr(`OFS_TALARM, 32'h00120010);
      wr(`OFS_TALARM, 32'h00120090);
      wr(`OFS_CALARM, 32'h81810000);
      rd(`OFS_CALARM, d); chk(d, 32'h81810000);
      wr(`OFS_CLEAR, 32'h2);
      poll(`ST_ALARM);
      rd(`OFS_TIME, d); chk(d & 32'hff, 32'h10);
      $display("alarm done");
    end
  endtask
  // halts both counters, presets them, then lets them run into the next tick
  task set_time(input [31:0] c, input [31:0] t, input [31:0] cl);
    begin
      wr(`OFS_CTRL, c | 32'h3);
      poll(`ST_ACK);
      wr(`OFS_TIME, t);
      wr(`OFS_CAL, cl);
      wr(`OFS_CLEAR, 32'h1f);
      wr(`OFS_CTRL, c);
      rd(`OFS_CTRL, d); chk(d, c);
      wait_time(t);
    end
  endtask
  task t_events;
    begin
      wr(`OFS_MODE, 32'h0);
      wr(`OFS_TALARM, 32'h00000060);
      wr(`OFS_CALARM, 32'h01130000);
      rd(`OFS_VALID, d); chk(d & 32'hc, 32'hc);
      set_time(32'h300, 32'h00115959, 32'h28e20420);
      chk(d, 32'h00120000);
      rd(`OFS_STATUS, d); chk(d & 32'h18, 32'h08);
      set_time(32'h100, 32'h00235959, 32'h28e20420);
      chk(d, 32'h0);
      rd(`OFS_CAL, d); chk(d, 32'h29220420);
      rd(`OFS_STATUS, d); chk(d & 32'h18, 32'h18);
      set_time(32'h10000, 32'h00235959, 32'h29220420);
      chk(d, 32'h0);
      rd(`OFS_CAL, d); chk(d, 32'h01430420);
      rd(`OFS_STATUS, d); chk(d & 32'h18, 32'h18);
      $display("events done");
    end
  endtask
  initial begin
    errors    = 0;
    testsRun  = 0;
    cycles    = 0;
    rst       = 1'b1;
    regAddr   = 32'h0;
    regWrData = 32'h0;
    regWr     = 1'b0;
    regRd     = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset;
    t_update;
    t_rollover;
    t_twelve;
    t_alarm;
    t_events;
    end_of_test;
  end
endmodule
